/* verilog/mic_supply_pkg.sv */
// Purpose: Shared constants and types for the microphone supply and button timing registers.
// Assumes: 250 MHz ref_clk; register map reached over the two-wire serial host port.
// Notes:   Times are kept in milliseconds and converted to cycle counts here.
`default_nettype none

package mic_supply_pkg;

  // Clock rate.
  localparam int CLK_KHZ = 250000;

  // Register offsets.
  localparam logic [7:0] OFS_POWER_ENABLES = 8'h03;
  localparam logic [7:0] OFS_VOLTAGE       = 8'h04;
  localparam logic [7:0] OFS_HOLD          = 8'h05;

  // Field positions.
  localparam int BIT_PUMP     = 3;
  localparam int BIT_SUPPLY   = 2;
  localparam int BIT_PREAMP   = 1;
  localparam int BIT_HPAMP    = 0;
  localparam int BIT_CV_FLAG  = 7;
  localparam int BIT_CD_FLAG  = 6;
  localparam int VSEL_LSB     = 0;
  localparam int HOLD_LSB     = 3;

  // Reset values and limits.
  localparam logic [3:0] RST_ENABLES = 4'hf;
  localparam logic [3:0] RST_VSEL    = 4'hb;
  localparam logic [3:0] VSEL_MAX    = 4'hd;
  localparam logic [2:0] RST_HOLD    = 3'h7;

  // Hold time codes.
  localparam logic [2:0] HOLD_CODE_5MS    = 3'h0;
  localparam logic [2:0] HOLD_CODE_500MS  = 3'h1;
  localparam logic [2:0] HOLD_CODE_1000MS = 3'h2;
  localparam logic [2:0] HOLD_CODE_2000MS = 3'h4;

  // Hold times and their cycle counts.
  localparam int HOLD_T5_MS    = 5;
  localparam int HOLD_T500_MS  = 500;
  localparam int HOLD_T1000_MS = 1000;
  localparam int HOLD_T2000_MS = 2000;
  localparam int HOLD_T2500_MS = 2500;
  localparam int HOLD_CYC_5    = HOLD_T5_MS * CLK_KHZ;
  localparam int HOLD_CYC_500  = HOLD_T500_MS * CLK_KHZ;
  localparam int HOLD_CYC_1000 = HOLD_T1000_MS * CLK_KHZ;
  localparam int HOLD_CYC_2000 = HOLD_T2000_MS * CLK_KHZ;
  localparam int HOLD_CYC_2500 = HOLD_T2500_MS * CLK_KHZ;
  localparam int CNT_W         = 30;

  // Serial port.
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_ADDR,
    I2C_ACK,
    I2C_WRITE,
    I2C_READ,
    I2C_MACK
  } i2c_state_type;

  typedef struct packed {
    logic pump;
    logic supply;
    logic preamp;
    logic hpAmp;
  } power_enables_type;

  typedef struct packed {
    logic cvMode;
    logic cdMode;
  } supply_mode_type;

  typedef struct packed {
    i2c_state_type     state;
    logic              sclPrev;
    logic              sdaPrev;
    logic [3:0]        bitCnt;
    logic [7:0]        shift;
    logic [7:0]        ptr;
    logic              rw;
    logic              first;
    logic              sdaOe;
    power_enables_type en;
    logic [3:0]        vsel;
    logic [2:0]        holdSel;
  } regs_state_type;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             fired;
    logic             req;
  } hold_state_type;

endpackage

`default_nettype wire

/* verilog/button_hold_timer.sv */
// Purpose: Measures how long the push button is held and requests power-down once it passes the limit.
// Assumes: buttonHeld is synchronous to ref_clk.
// Notes:   One request per press; the button must be released before another can follow.
`default_nettype none

module button_hold_timer #(
  parameter int CNT_W = mic_supply_pkg::CNT_W
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Button and limit.
  input  wire logic             buttonHeld,
  input  wire logic [CNT_W-1:0] holdCycles,
  // Result.
  output logic                  powerDownReq
);

  // The count must fit a signed int and hold at least the shortest limit.
  if (CNT_W < 2 || CNT_W > 31) begin : g_bad_width
    $error("button_hold_timer: CNT_W out of range");
  end

  mic_supply_pkg::hold_state_type st_reg;
  mic_supply_pkg::hold_state_type st_next;

  always_comb begin
    st_next     = st_reg;
    st_next.req = 1'b0;
    if (!buttonHeld) begin
      st_next.cnt   = '0;
      st_next.fired = 1'b0;
    end else if (!st_reg.fired) begin
      if (st_reg.cnt >= holdCycles - CNT_W'(1)) begin
        st_next.req   = 1'b1;
        st_next.fired = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign powerDownReq = st_reg.req;

endmodule // button_hold_timer

`default_nettype wire

/* verilog/mic_supply_regs.sv */
// Purpose: Microphone supply, amplifier enable and button hold time registers behind a two-wire serial port.
// Assumes: sclIn/sdaIn already synchronous to ref_clk and much slower than it; open-drain data line.
// Notes:   One byte pointer, auto-increment on every written data byte and every host-acknowledged read byte, unmapped offsets read zero and ignore writes.
// Functional notes
// - Bias charge pump follows its bit, default on.
// - Supply regulator follows its bit, default on.
// - Preamplifier follows its bit, default on.
// - Headphone amplifier follows its bit, default on.
// - Bit 7 reads constant-voltage mode flag.
// - Bit 6 reads constant-drop mode flag.
// - Voltage code 0..13, default 11; never 14/15.
// - Power-down only after button held selected time.
// - Hold codes decode to 5..2500 ms.
// - Hold time applies in every control mode.
// - All registers reachable over serial port always.
`default_nettype none

module mic_supply_regs #(
  parameter logic [6:0] DEV_ADDR   = 7'h2a, // Arbitrary serial address.
  parameter int         CYC_5MS    = mic_supply_pkg::HOLD_CYC_5,
  parameter int         CYC_500MS  = mic_supply_pkg::HOLD_CYC_500,
  parameter int         CYC_1000MS = mic_supply_pkg::HOLD_CYC_1000,
  parameter int         CYC_2000MS = mic_supply_pkg::HOLD_CYC_2000,
  parameter int         CYC_2500MS = mic_supply_pkg::HOLD_CYC_2500
) (
  // Clock and reset.
  input  wire logic                              ref_clk,
  input  wire logic                              rstn,
  // Serial host port.
  input  wire logic                              sclIn,
  input  wire logic                              sdaIn,
  output logic                                   sdaOut,
  output logic                                   sdaOe,
  // Analog status and button.
  input  wire mic_supply_pkg::supply_mode_type   supplyMode,
  input  wire logic                              buttonHeld,
  // Analog controls.
  output mic_supply_pkg::power_enables_type      powerEnables,
  output logic [3:0]                             micSupplyVoltageSelect,
  output logic                                   powerDownReq
);

  localparam int CW = mic_supply_pkg::CNT_W;

  // The timer compares against count minus one, so zero would wrap.
  if (CYC_5MS < 1 || CYC_500MS < 1 || CYC_1000MS < 1 || CYC_2000MS < 1 || CYC_2500MS < 1) begin : g_bad_count
    $error("mic_supply_regs: hold counts must be at least one cycle");
  end
  if (CYC_5MS >= (1 << CW) || CYC_500MS >= (1 << CW) || CYC_1000MS >= (1 << CW) ||
      CYC_2000MS >= (1 << CW) || CYC_2500MS >= (1 << CW)) begin : g_bad_width
    $error("mic_supply_regs: hold counts exceed counter width");
  end

  mic_supply_pkg::regs_state_type st_reg;
  mic_supply_pkg::regs_state_type st_next;

  logic          sclRise;
  logic          sclFall;
  logic          startCond;
  logic          stopCond;
  logic [7:0]    readData;
  logic [CW-1:0] holdCycles;

  assign sclRise   = sclIn & ~st_reg.sclPrev;
  assign sclFall   = ~sclIn & st_reg.sclPrev;
  assign startCond = sclIn & st_reg.sclPrev & st_reg.sdaPrev & ~sdaIn;
  assign stopCond  = sclIn & st_reg.sclPrev & ~st_reg.sdaPrev & sdaIn;

  // Read mux; the mode flags are sampled live, never stored.
  always_comb begin
    readData = 8'h00;
    case (st_reg.ptr)
      mic_supply_pkg::OFS_POWER_ENABLES: begin
        readData[mic_supply_pkg::BIT_PUMP]   = st_reg.en.pump;
        readData[mic_supply_pkg::BIT_SUPPLY] = st_reg.en.supply;
        readData[mic_supply_pkg::BIT_PREAMP] = st_reg.en.preamp;
        readData[mic_supply_pkg::BIT_HPAMP]  = st_reg.en.hpAmp;
      end
      mic_supply_pkg::OFS_VOLTAGE: begin
        readData[mic_supply_pkg::BIT_CV_FLAG] = supplyMode.cvMode;
        readData[mic_supply_pkg::BIT_CD_FLAG] = supplyMode.cdMode;
        readData[mic_supply_pkg::VSEL_LSB +: 4] = st_reg.vsel;
      end
      mic_supply_pkg::OFS_HOLD: begin
        readData[mic_supply_pkg::HOLD_LSB +: 3] = st_reg.holdSel;
      end
      default: begin
        readData = 8'h00;
      end
    endcase
  end

  always_comb begin
    st_next         = st_reg;
    st_next.sclPrev = sclIn;
    st_next.sdaPrev = sdaIn;
    if (startCond) begin
      st_next.state  = mic_supply_pkg::I2C_ADDR;
      st_next.bitCnt = 4'h0;
      st_next.first  = 1'b1;
      st_next.sdaOe  = 1'b0;
    end else if (stopCond) begin
      st_next.state = mic_supply_pkg::I2C_IDLE;
      st_next.sdaOe = 1'b0;
    end else begin
      case (st_reg.state)
        mic_supply_pkg::I2C_ADDR, mic_supply_pkg::I2C_WRITE: begin
          if (sclRise && st_reg.bitCnt != mic_supply_pkg::BITS_PER_BYTE) begin
            st_next.shift  = {st_reg.shift[6:0], sdaIn};
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
          end else if (sclFall && st_reg.bitCnt == mic_supply_pkg::BITS_PER_BYTE) begin
            st_next.bitCnt = 4'h0;
            if (st_reg.state == mic_supply_pkg::I2C_ADDR) begin
              if (st_reg.shift[7:1] == DEV_ADDR) begin
                st_next.rw    = st_reg.shift[0];
                st_next.state = mic_supply_pkg::I2C_ACK;
                st_next.sdaOe = 1'b1;
              end else begin
                st_next.state = mic_supply_pkg::I2C_IDLE;
              end
            end else begin
              if (st_reg.first) begin
                st_next.ptr = st_reg.shift;
              end else begin
                // Every register is writable regardless of any mode control bit.
                case (st_reg.ptr)
                  mic_supply_pkg::OFS_POWER_ENABLES: begin
                    st_next.en.pump   = st_reg.shift[mic_supply_pkg::BIT_PUMP];
                    st_next.en.supply = st_reg.shift[mic_supply_pkg::BIT_SUPPLY];
                    st_next.en.preamp = st_reg.shift[mic_supply_pkg::BIT_PREAMP];
                    st_next.en.hpAmp  = st_reg.shift[mic_supply_pkg::BIT_HPAMP];
                  end
                  mic_supply_pkg::OFS_VOLTAGE: begin
                    // Flag bits are dropped; forbidden voltage codes leave the old code in place.
                    if (st_reg.shift[mic_supply_pkg::VSEL_LSB +: 4] <= mic_supply_pkg::VSEL_MAX) begin
                      st_next.vsel = st_reg.shift[mic_supply_pkg::VSEL_LSB +: 4];
                    end
                  end
                  mic_supply_pkg::OFS_HOLD: begin
                    st_next.holdSel = st_reg.shift[mic_supply_pkg::HOLD_LSB +: 3];
                  end
                  default: begin
                    st_next.holdSel = st_reg.holdSel;
                  end
                endcase
                st_next.ptr = st_reg.ptr + 8'h01;
              end
              st_next.first = 1'b0;
              st_next.state = mic_supply_pkg::I2C_ACK;
              st_next.sdaOe = 1'b1;
            end
          end
        end
        mic_supply_pkg::I2C_ACK: begin
          if (sclFall) begin
            st_next.bitCnt = 4'h0;
            if (st_reg.rw) begin
              st_next.shift = readData;
              st_next.sdaOe = ~readData[7];
              st_next.state = mic_supply_pkg::I2C_READ;
            end else begin
              st_next.sdaOe = 1'b0;
              st_next.state = mic_supply_pkg::I2C_WRITE;
            end
          end
        end
        mic_supply_pkg::I2C_READ: begin
          if (sclRise) begin
            st_next.bitCnt = st_reg.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (st_reg.bitCnt == mic_supply_pkg::BITS_PER_BYTE) begin
              st_next.sdaOe = 1'b0;
              st_next.state = mic_supply_pkg::I2C_MACK;
            end else begin
              st_next.sdaOe = ~st_reg.shift[3'(4'h7 - st_reg.bitCnt)];
            end
          end
        end
        mic_supply_pkg::I2C_MACK: begin
          if (sclRise) begin
            if (sdaIn) begin
              st_next.state = mic_supply_pkg::I2C_IDLE;
            end else begin
              st_next.ptr   = st_reg.ptr + 8'h01;
              st_next.state = mic_supply_pkg::I2C_ACK;
            end
          end
        end
        default: begin
          st_next.state = mic_supply_pkg::I2C_IDLE;
          st_next.sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg         <= '0;
      st_reg.state   <= mic_supply_pkg::I2C_IDLE;
      st_reg.sclPrev <= 1'b1;
      st_reg.sdaPrev <= 1'b1;
      st_reg.en      <= mic_supply_pkg::RST_ENABLES;
      st_reg.vsel    <= mic_supply_pkg::RST_VSEL;
      st_reg.holdSel <= mic_supply_pkg::RST_HOLD;
    end else begin
      st_reg <= st_next;
    end
  end

  // Undefined codes 3, 5, 6 and 7 fall back to the longest time.
  always_comb begin
    case (st_reg.holdSel)
      mic_supply_pkg::HOLD_CODE_5MS:    holdCycles = CW'(CYC_5MS);
      mic_supply_pkg::HOLD_CODE_500MS:  holdCycles = CW'(CYC_500MS);
      mic_supply_pkg::HOLD_CODE_1000MS: holdCycles = CW'(CYC_1000MS);
      mic_supply_pkg::HOLD_CODE_2000MS: holdCycles = CW'(CYC_2000MS);
      default:                          holdCycles = CW'(CYC_2500MS);
    endcase
  end

  // The button level comes from whichever control style is fitted.
  button_hold_timer #(
    .CNT_W (CW)
  ) holdTimer (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .buttonHeld   (buttonHeld),
    .holdCycles   (holdCycles),
    .powerDownReq (powerDownReq)
  );

  assign sdaOut                 = 1'b0;
  assign sdaOe                  = st_reg.sdaOe;
  assign powerEnables           = st_reg.en;
  assign micSupplyVoltageSelect = st_reg.vsel;

endmodule // mic_supply_regs

`default_nettype wire

/* verification/mic_supply_regs_sva.sv */
// Purpose: Port assertions for the microphone supply and button timing registers.
// Assumes: One clock domain; rstn is asynchronous and active low.
// Notes:   CYC_5MS is the shortest hold count the design is built with.
`default_nettype none

module mic_supply_regs_sva #(
  parameter int CYC_5MS = 4
) (
  // Clock and reset.
  input wire logic                            ref_clk,
  input wire logic                            rstn,
  // Serial host port.
  input wire logic                            sclIn,
  input wire logic                            sdaIn,
  input wire logic                            sdaOut,
  input wire logic                            sdaOe,
  // Status, button and controls.
  input wire mic_supply_pkg::supply_mode_type   supplyMode,
  input wire logic                            buttonHeld,
  input wire mic_supply_pkg::power_enables_type powerEnables,
  input wire logic [3:0]                      micSupplyVoltageSelect,
  input wire logic                            powerDownReq
);
  logic [7:0] heldRun_reg;
  logic       fired_reg;

  // Counts consecutive held cycles and remembers a pulse until release.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      heldRun_reg <= 8'h00;
      fired_reg   <= 1'b0;
    end else begin
      heldRun_reg <= !buttonHeld ? 8'h00 : heldRun_reg + {7'h00, heldRun_reg != 8'hff};
      fired_reg   <= buttonHeld && (fired_reg || powerDownReq);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_reset_values:
    assert property ($rose(rstn) |-> powerEnables == 4'hf && micSupplyVoltageSelect == 4'hb && !sdaOe)
    else $error("reset values wrong");
  a_vsel_legal:
    assert property (micSupplyVoltageSelect <= 4'hd) else $error("voltage code out of range");
  a_vsel_on_fall:
    assert property ($changed(micSupplyVoltageSelect) |-> !sclIn && !$past(sclIn)) else $error("voltage moved");
  a_enables_on_fall:
    assert property ($changed(powerEnables) |-> !sclIn && !$past(sclIn)) else $error("enables moved");
  a_oe_scl_low:
    assert property ($changed(sdaOe) |-> !sclIn) else $error("data line changed with clock high");
  a_sda_drive_low:
    assert property (sdaOut == 1'b0) else $error("data line driven high");
  a_req_pulse:
    assert property (powerDownReq |=> !powerDownReq) else $error("request longer than a cycle");
  a_req_after_hold:
    assert property (powerDownReq |-> heldRun_reg >= CYC_5MS) else $error("request before hold time");
  a_req_once:
    assert property (powerDownReq |-> !fired_reg) else $error("second request in one press");

  c_pulse: cover property (powerDownReq);
  c_ack: cover property ($rose(sdaOe));
  c_vsel: cover property ($changed(micSupplyVoltageSelect));
endmodule // mic_supply_regs_sva

bind mic_supply_regs mic_supply_regs_sva #(.CYC_5MS(CYC_5MS)) chk (
  .ref_clk(ref_clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .supplyMode(supplyMode), .buttonHeld(buttonHeld), .powerEnables(powerEnables),
  .micSupplyVoltageSelect(micSupplyVoltageSelect), .powerDownReq(powerDownReq));

`default_nettype wire

/* verification/i2c_host_model.sv */
// Purpose: Two-wire serial host that writes and reads the register slice.
// Assumes: Lines change 1 ns after a clock edge; each clock phase lasts PH cycles.
// Notes:   sda high releases the line; sdaLine is the resolved wire.
`default_nettype none

module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int         PH   = 4
) (
  // Clock.
  input  wire logic clk,
  // Resolved data line.
  input  wire logic sdaLine,
  // Host drive levels.
  output var logic  scl,
  output var logic  sda
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Start or repeated start, ending with the clock low.
  task automatic start_cond();
    sda = 1'b1;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    sda = 1'b0;
    tick(PH);
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    sda = 1'b0;
    tick(PH);
    scl = 1'b1;
    tick(PH);
    sda = 1'b1;
    tick(PH);
  endtask

  // Eight data bits then the acknowledge bit, sampled mid high phase.
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda = tx[i];
      tick(PH);
      scl = 1'b1;
      tick(PH / 2);
      rx[i] = sdaLine;
      tick(PH / 2);
      scl = 1'b0;
    end
  endtask

  task automatic write_reg(input logic [6:0] a, input logic [7:0] p, d, output logic ok);
    logic [8:0] r0, r1, r2;
    start_cond();
    xfer({a, 1'b0, 1'b1}, r0);
    xfer({p, 1'b1}, r1);
    xfer({d, 1'b1}, r2);
    stop_cond();
    ok = !r0[0] && !r1[0] && !r2[0];
  endtask

  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    logic [8:0] r;
    start_cond();
    xfer({ADDR, 1'b0, 1'b1}, r);
    xfer({p, 1'b1}, r);
    start_cond();
    xfer({ADDR, 1'b1, 1'b1}, r);
    xfer(9'h1ff, r);
    d = r[8:1];
    stop_cond();
  endtask

  // Two data bytes in one write, relying on pointer auto-increment.
  task automatic write_pair(input logic [7:0] p, d0, d1, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    start_cond();
    xfer({ADDR, 1'b0, 1'b1}, r0);
    xfer({p, 1'b1}, r1);
    xfer({d0, 1'b1}, r2);
    xfer({d1, 1'b1}, r3);
    stop_cond();
    ok = !r0[0] && !r1[0] && !r2[0] && !r3[0];
  endtask

  // Two bytes read; the host acknowledges the first so the pointer advances.
  task automatic read_pair(input logic [7:0] p, output logic [7:0] d0, d1);
    logic [8:0] r;
    start_cond();
    xfer({ADDR, 1'b0, 1'b1}, r);
    xfer({p, 1'b1}, r);
    start_cond();
    xfer({ADDR, 1'b1, 1'b1}, r);
    xfer(9'h1fe, r);
    d0 = r[8:1];
    xfer(9'h1ff, r);
    d1 = r[8:1];
    stop_cond();
  endtask
endmodule // i2c_host_model

`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench for the microphone supply and button timing registers.
// Assumes: Hold counts shortened to 4, 8, 12, 16 and 20 cycles.
// Notes:   All register traffic goes through the serial host model.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         CYC [6]  = '{4, 8, 12, 16, 20, 20};
  localparam logic [2:0] CODE [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};

  logic                              ref_clk;
  logic                              rstn;
  logic                              sclIn;
  logic                              sdaHost;
  logic                              sdaOut;
  logic                              sdaOe;
  logic                              buttonHeld;
  logic                              powerDownReq;
  logic [3:0]                        micSupplyVoltageSelect;
  mic_supply_pkg::supply_mode_type   supplyMode;
  mic_supply_pkg::power_enables_type powerEnables;
  wire logic                         sdaIn = sdaHost & ~sdaOe;
  int                                n_mismatch = 0;
  int                                checks_done = 0;

  mic_supply_regs #(.DEV_ADDR(7'h2a), .CYC_5MS(CYC[0]), .CYC_500MS(CYC[1]), .CYC_1000MS(CYC[2]),
    .CYC_2000MS(CYC[3]), .CYC_2500MS(CYC[4])) uut (
    .ref_clk(ref_clk), .rstn(rstn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .supplyMode(supplyMode), .buttonHeld(buttonHeld), .powerEnables(powerEnables),
    .micSupplyVoltageSelect(micSupplyVoltageSelect), .powerDownReq(powerDownReq));

  i2c_host_model host (.clk(ref_clk), .sdaLine(sdaIn), .scl(sclIn), .sda(sdaHost));

  always #2 ref_clk = ~ref_clk;

  task automatic check(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Holds the button for m cycles; n is the cycle of the first request, 0 if none.
  task automatic press(input int m, output int n);
    n = 0;
    buttonHeld = 1'b1;
    for (int i = 1; i <= m; i++) begin
      @(posedge ref_clk);
      #1;
      if (powerDownReq === 1'b1 && n == 0) n = i;
    end
    buttonHeld = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask

  initial begin
    logic [7:0] d;
    logic [7:0] e;
    logic [3:0] v;
    logic       ok;
    int         n;
    ref_clk = 1'b0;
    rstn = 1'b0;
    buttonHeld = 1'b0;
    supplyMode = 2'b00;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'b1;
    check(powerEnables, 4'hf);
    check(micSupplyVoltageSelect, 4'hb);
    host.read_reg(8'h05, d);
    check(d, 8'h38);
    for (int i = 0; i < 4; i++) begin
      host.write_reg(7'h2a, 8'h03, 8'h0f ^ (8'h01 << i), ok);
      check({ok, powerEnables}, {1'b1, 4'hf ^ (4'h1 << i)});
      host.read_reg(8'h03, d);
      check(d, 8'h0f ^ (8'h01 << i));
    end
    for (int c = 0; c < 16; c++) begin
      supplyMode = 2'(c);
      host.write_reg(7'h2a, 8'h04, 8'hc0 | 8'(c), ok);
      v = (c > 13) ? 4'hd : 4'(c);
      check(micSupplyVoltageSelect, v);
      host.read_reg(8'h04, d);
      check(d, {2'(c), 2'b00, v});
    end
    host.write_reg(7'h2b, 8'h04, 8'h00, ok);
    check({ok, micSupplyVoltageSelect}, {1'b0, 4'hd});
    host.read_reg(8'h07, d);
    check(d, 8'h00);
    for (int k = 0; k < 6; k++) begin
      host.write_reg(7'h2a, 8'h05, {2'b00, CODE[k], 3'h0}, ok);
      host.read_reg(8'h05, d);
      check(d, {2'b00, CODE[k], 3'h0});
      press(CYC[k] + 4, n);
      check(n, CYC[k]);
    end
    press(CYC[5] - 1, n);
    check(n, 0);
    host.write_pair(8'h04, 8'h03, 8'h28, ok);
    check({ok, micSupplyVoltageSelect}, {1'b1, 4'h3});
    host.read_pair(8'h04, d, e);
    check(d, 8'hc3);
    check(e, 8'h28);
    @(posedge ref_clk);
    #1 rstn = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 rstn = 1'b1;
    check({powerEnables, micSupplyVoltageSelect}, {4'hf, 4'hb});
    host.read_reg(8'h05, d);
    check(d, 8'h38);
    summarize();
  end
endmodule // tb

`default_nettype wire
